// *** hw/sbta_pkg.sv ***
// constants, field layout and mode codes of the sixteen-bit timer with byte-wide access
// Overview of operation
// RULE1: a count of all zeros is the bottom of the sequence
// RULE2: a count of all ones is the maximum
// RULE3: mode picks top from three fixed values, compare A or capture register
// RULE4: with no clock source selected the counter stays still
// RULE5: each buffered compare value is matched against the count and sets its flag
// RULE6: compare A as pulse-width top gives no output and is double buffered
// RULE7: selected edge on capture pin, optionally filtered, copies count into capture register
// RULE8: one eight-bit temporary high byte is shared by all sixteen-bit registers
// RULE9: writing a low byte loads temporary high byte and low byte together
// RULE10: reading a low byte copies that register's high byte into the temporary
// RULE11: compare register reads bypass the temporary register entirely
// RULE12: software writes the high byte before the low byte
// RULE13: software reads the low byte before the high byte
// RULE14: the power gate bit must be cleared; while set the timer is disabled
// RULE15: ticks come from prescaler or external count pin with selectable edge
// RULE16: every request shows in the flag register and is gated by a mask bit
// RULE17: control registers are eight bits, taken in one access, no ordering
// RULE18: compare results drive pulse-width or frequency signals on compare pins
// RULE19: high-byte writes fill the temporary only; high-byte reads return it
package sbta_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRE_W = 10;
  localparam int unsigned NUM_FLAGS = 4;
  localparam int unsigned FILT_LEN_DEF = 4;

  // ----------------------------------------------------------------
  // count limits
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // register byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_CNT_LO = 8'h0c;
  localparam logic [7:0] OFS_CNT_HI = 8'h10;
  localparam logic [7:0] OFS_CMPA_LO = 8'h14;
  localparam logic [7:0] OFS_CMPA_HI = 8'h18;
  localparam logic [7:0] OFS_CMPB_LO = 8'h1c;
  localparam logic [7:0] OFS_CMPB_HI = 8'h20;
  localparam logic [7:0] OFS_CAP_LO = 8'h24;
  localparam logic [7:0] OFS_CAP_HI = 8'h28;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRLB_EDGE_BIT = 3;
  localparam int unsigned CTRLB_FILT_BIT = 4;
  localparam int unsigned CTRLC_GATE_BIT = 0;
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_CMPA = 1;
  localparam int unsigned FLG_CMPB = 2;
  localparam int unsigned FLG_CAP = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic GATE_RST = 1'b0;

  // ----------------------------------------------------------------
  // clock select codes and prescaler masks
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PWM8 = 3'b001,
    MODE_PWM9 = 3'b010,
    MODE_PWM10 = 3'b011,
    MODE_CTC_A = 3'b100,
    MODE_CTC_CAP = 3'b101,
    MODE_PWM_CAP = 3'b110,
    MODE_PWM_A = 3'b111
  } sbta_mode_e;

endpackage

// *** hw/sbta_top.sv ***
// sixteen-bit timer with shared high-byte register, capture, compares and bus slave
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module sbta_top import sbta_pkg::*; #(
  parameter int unsigned FILT_LEN = FILT_LEN_DEF
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic external_count_pin_in,
  input wire logic capture_input_pin_in,
  output logic compare_output_pin_a_out,
  output logic compare_output_pin_b_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic gate;
    logic [15:0] count_value;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpa;
    logic [15:0] cmpb_buf;
    logic [15:0] cmpb;
    logic [15:0] cap;
    logic [7:0] temp;
    logic [7:0] snap_hi;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [9:0] presc;
    logic ext_prev;
    logic [FILT_LEN-1:0] cap_hist;
    logic cap_filt;
    logic cap_prev;
    logic oc_a;
    logic oc_b;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sbta_state_s;

  sbta_state_s st_q;
  sbta_state_s st_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_pwm_f(input sbta_mode_e m);
    return (m == MODE_PWM8) || (m == MODE_PWM9) || (m == MODE_PWM10) ||
           (m == MODE_PWM_CAP) || (m == MODE_PWM_A);
  endfunction

  // top of the sequence per mode
  function automatic logic [15:0] top_f(input sbta_mode_e m, input logic [15:0] a,
                                        input logic [15:0] c);
    logic [15:0] t;
    t = CNT_MAX;
    case (m)
      MODE_PWM8: t = TOP_8;
      MODE_PWM9: t = TOP_9;
      MODE_PWM10: t = TOP_10;
      MODE_CTC_A, MODE_PWM_A: t = a;
      MODE_CTC_CAP, MODE_PWM_CAP: t = c;
      default: t = CNT_MAX;
    endcase
    return t; // RULE3
  endfunction

  // clock select: prescaler taps or external pin edge
  function automatic logic tick_f(input logic [2:0] cs, input logic [9:0] p,
                                  input logic ee);
    logic t;
    t = 1'b0;
    case (cs)
      CS_DIV1: t = 1'b1;
      CS_DIV8: t = (p & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64: t = (p & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256: t = (p & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024: t = (p & PRE_MASK_1024) == PRE_MASK_1024;
      CS_EXT_FALL, CS_EXT_RISE: t = ee;
      default: t = 1'b0; // no source: counter idle
    endcase
    return t; // RULE15 RULE4
  endfunction

  sbta_mode_e mode;
  logic [2:0] clk_sel;
  logic is_pwm;
  logic [15:0] top_val;
  logic at_bottom;
  logic at_top;
  logic ext_edge;
  logic tick;
  logic wrap;
  logic match_a;
  logic match_b;
  logic cap_sel;
  logic cap_evt;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;

  assign mode = sbta_mode_e'(st_q.ctrl_a[2:0]);
  assign clk_sel = st_q.ctrl_b[2:0];
  assign is_pwm = is_pwm_f(mode);
  assign top_val = top_f(mode, st_q.cmpa, st_q.cap);
  assign at_bottom = st_q.count_value == CNT_BOTTOM; // RULE1
  assign at_top = st_q.count_value == top_val;
  // external edge uses the pin as sampled; pin is taken as synchronous
  assign ext_edge = (clk_sel == CS_EXT_RISE) ?
                    (external_count_pin_in && !st_q.ext_prev) :
                    (!external_count_pin_in && st_q.ext_prev); // RULE15
  // a set power gate stops every tick
  assign tick = !st_q.gate && tick_f(clk_sel, st_q.presc, ext_edge); // RULE14 RULE4
  assign wrap = tick && at_top;
  assign match_a = tick && (st_q.count_value == st_q.cmpa); // RULE5
  assign match_b = tick && (st_q.count_value == st_q.cmpb); // RULE5
  // filtered or raw sample, edge chosen by control bit
  assign cap_sel = st_q.ctrl_b[CTRLB_FILT_BIT] ? st_q.cap_filt : st_q.cap_hist[0];
  // capture register is frozen while it serves as top
  assign cap_evt = !st_q.gate && (mode != MODE_CTC_CAP) && (mode != MODE_PWM_CAP) &&
                   (st_q.ctrl_b[CTRLB_EDGE_BIT] ? (cap_sel && !st_q.cap_prev) :
                   (!cap_sel && st_q.cap_prev)); // RULE7
  assign setup = psel_in && !penable_in;
  assign acc = psel_in && penable_in && st_q.pready;
  assign wr = acc && pwrite_in;
  assign rd = acc && !pwrite_in;
  assign mapped = (paddr_in <= OFS_IRQ_MASK) && (paddr_in[1:0] == 2'b00);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] set_v;
    logic [3:0] clr_v;
    set_v = '0;
    clr_v = '0;
    st_d = st_q;
    // prescaler only runs while a source is chosen
    if (clk_sel == CS_NONE || st_q.gate) begin
      st_d.presc = '0;
    end else begin
      st_d.presc = st_q.presc + 10'h001;
    end
    st_d.ext_prev = external_count_pin_in;
    // noise filter: output moves only after a full run of equal samples
    st_d.cap_hist = {st_q.cap_hist[FILT_LEN-2:0], capture_input_pin_in};
    if (&st_q.cap_hist) begin
      st_d.cap_filt = 1'b1; // RULE7
    end else if (~|st_q.cap_hist) begin
      st_d.cap_filt = 1'b0;
    end
    st_d.cap_prev = cap_sel;
    // counter: wrap at top, otherwise step
    if (tick) begin
      st_d.count_value = wrap ? CNT_BOTTOM : st_q.count_value + CNT_STEP; // RULE2 RULE3
    end
    // compare buffers: pwm modes load at top so the period never tears
    if (!is_pwm) begin
      st_d.cmpa = st_q.cmpa_buf;
      st_d.cmpb = st_q.cmpb_buf;
    end else if (wrap) begin
      st_d.cmpa = st_q.cmpa_buf; // RULE6
      st_d.cmpb = st_q.cmpb_buf; // RULE5
    end
    set_v[FLG_OVF] = wrap;
    set_v[FLG_CMPA] = match_a; // RULE5
    set_v[FLG_CMPB] = match_b; // RULE5
    set_v[FLG_CAP] = cap_evt;
    // waveform: pwm sets at bottom and clears on match, else toggle
    if (is_pwm) begin
      if (tick && at_bottom) begin
        st_d.oc_a = 1'b1;
        st_d.oc_b = 1'b1; // RULE1 RULE18
      end
      if (match_a) begin
        st_d.oc_a = 1'b0;
      end
      if (match_b) begin
        st_d.oc_b = 1'b0; // RULE18
      end
    end else begin
      if (match_a) begin
        st_d.oc_a = !st_q.oc_a;
      end
      if (match_b) begin
        st_d.oc_b = !st_q.oc_b; // RULE18
      end
    end
    if (mode == MODE_PWM_A) begin
      st_d.oc_a = 1'b0; // RULE6
    end
    if (cap_evt) begin
      st_d.cap = st_q.count_value; // RULE7
    end
    // bus: answer registered in setup, so pready is high in the first access cycle
    st_d.pready = setup;
    st_d.pslverr = setup && !mapped;
    if (setup && !pwrite_in) begin
      st_d.prdata = '0;
      case (paddr_in)
        OFS_CTRL_A: st_d.prdata[7:0] = st_q.ctrl_a; // RULE17
        OFS_CTRL_B: st_d.prdata[7:0] = st_q.ctrl_b;
        OFS_CTRL_C: st_d.prdata[CTRLC_GATE_BIT] = st_q.gate;
        OFS_CNT_LO: begin
          // snapshot the high byte now so both halves belong to one count
          st_d.prdata[7:0] = st_q.count_value[7:0];
          st_d.snap_hi = st_q.count_value[15:8]; // RULE10
        end
        OFS_CAP_LO: begin
          st_d.prdata[7:0] = st_q.cap[7:0];
          st_d.snap_hi = st_q.cap[15:8]; // RULE10
        end
        OFS_CNT_HI, OFS_CAP_HI: st_d.prdata[7:0] = st_q.temp; // RULE19
        OFS_CMPA_LO: st_d.prdata[7:0] = st_q.cmpa_buf[7:0]; // RULE11
        OFS_CMPA_HI: st_d.prdata[7:0] = st_q.cmpa_buf[15:8]; // RULE11
        OFS_CMPB_LO: st_d.prdata[7:0] = st_q.cmpb_buf[7:0]; // RULE11
        OFS_CMPB_HI: st_d.prdata[7:0] = st_q.cmpb_buf[15:8]; // RULE11
        OFS_IRQ_FLAG: st_d.prdata[3:0] = st_q.flags; // RULE16
        OFS_IRQ_MASK: st_d.prdata[3:0] = st_q.mask;
        default: st_d.prdata = '0;
      endcase
    end
    // count and capture low-byte reads commit the snapshot into the shared high byte
    if (rd && (paddr_in == OFS_CNT_LO || paddr_in == OFS_CAP_LO)) begin
      st_d.temp = st_q.snap_hi; // RULE10 RULE8
    end
    if (wr) begin
      case (paddr_in)
        OFS_CTRL_A: st_d.ctrl_a = pwdata_in[7:0]; // RULE17
        OFS_CTRL_B: st_d.ctrl_b = pwdata_in[7:0]; // RULE17
        OFS_CTRL_C: st_d.gate = pwdata_in[CTRLC_GATE_BIT]; // RULE14
        OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI, OFS_CAP_HI: begin
          st_d.temp = pwdata_in[7:0]; // RULE19 RULE8
        end
        OFS_CNT_LO: st_d.count_value = {st_q.temp, pwdata_in[7:0]}; // RULE9
        OFS_CMPA_LO: st_d.cmpa_buf = {st_q.temp, pwdata_in[7:0]}; // RULE9
        OFS_CMPB_LO: st_d.cmpb_buf = {st_q.temp, pwdata_in[7:0]}; // RULE9
        OFS_CAP_LO: st_d.cap = {st_q.temp, pwdata_in[7:0]}; // RULE9
        OFS_IRQ_FLAG: clr_v = pwdata_in[3:0];
        OFS_IRQ_MASK: st_d.mask = pwdata_in[3:0]; // RULE16
        default: st_d.mask = st_q.mask;
      endcase
    end
    // an event in the clearing cycle survives
    st_d.flags = (st_q.flags & ~clr_v) | set_v; // RULE16
    st_d.irq = |(st_d.flags & st_d.mask); // RULE16
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
      st_q.ctrl_a <= CTRL_RST;
      st_q.ctrl_b <= CTRL_RST;
      st_q.gate <= GATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_out = st_q.prdata;
  assign pready_out = st_q.pready;
  assign pslverr_out = st_q.pslverr;
  assign compare_output_pin_a_out = st_q.oc_a;
  assign compare_output_pin_b_out = st_q.oc_b;
  assign irq_out = st_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_stop_idle: assert property ((clk_sel == CS_NONE) && !wr |=> // RULE4
    st_q.count_value == $past(st_q.count_value)) else $error("counter moved without source");
  a_gate_hold: assert property (st_q.gate && !wr |=> $stable(st_q.count_value)) // RULE14
    else $error("counter moved while gated");
  a_max_wrap: assert property ((mode == MODE_NORMAL) && tick && // RULE2
    (st_q.count_value == CNT_MAX) && !wr |=> at_bottom && st_q.flags[FLG_OVF])
    else $error("no wrap with overflow at maximum");
  a_top_fixed: assert property ((mode == MODE_PWM9) && tick && // RULE3
    (st_q.count_value == TOP_9) && !wr |=> st_q.count_value == CNT_BOTTOM)
    else $error("fixed top not honoured");
  a_bottom_set: assert property (is_pwm && tick && at_bottom && // RULE1
    (st_q.cmpb != CNT_BOTTOM) |=> compare_output_pin_b_out)
    else $error("pwm output not set at bottom");
  a_cmpb_flag: assert property (match_b && !wr |=> st_q.flags[FLG_CMPB]) // RULE5
    else $error("compare b flag missing");
  a_pwm_a_quiet: assert property ((mode == MODE_PWM_A) |=> !compare_output_pin_a_out) // RULE6
    else $error("output from compare a used as top");
  a_cap_copy: assert property (cap_evt && !wr |=> st_q.cap == $past(st_q.count_value)) // RULE7
    else $error("capture value wrong");
  a_low_write: assert property (wr && (paddr_in == OFS_CNT_LO) |=> // RULE9
    st_q.count_value == {$past(st_q.temp), $past(pwdata_in[7:0])})
    else $error("low write did not join temporary byte");
  a_low_read: assert property (setup && !pwrite_in && (paddr_in == OFS_CNT_LO) ##1 // RULE10
    (rd && (paddr_in == OFS_CNT_LO)) |=> st_q.temp == $past(st_q.count_value[15:8], 2))
    else $error("low read did not latch high byte");
  a_cmp_read_keep: assert property (rd && (paddr_in == OFS_CMPA_HI || // RULE11
    paddr_in == OFS_CMPB_LO) |=> $stable(st_q.temp))
    else $error("compare read touched temporary");
  a_high_write: assert property (wr && (paddr_in == OFS_CAP_HI) |=> // RULE19
    st_q.temp == $past(pwdata_in[7:0])) else $error("high write missed temporary");
  a_ext_edge: assert property ((clk_sel == CS_EXT_RISE) && !st_q.gate && !wr && // RULE15
    external_count_pin_in && !st_q.ext_prev && !at_top |=>
    st_q.count_value != $past(st_q.count_value)) else $error("external edge not counted");
  a_irq_level: assert property (irq_out == |(st_q.flags & st_q.mask)) // RULE16
    else $error("interrupt level disagrees with flags");
  a_one_access: assert property (setup |=> pready_out ##1 !pready_out) // RULE17
    else $error("access phase not single cycle");
  a_wave_toggle: assert property (!is_pwm && (mode != MODE_PWM_A) && match_b |=> // RULE18
    compare_output_pin_b_out != $past(compare_output_pin_b_out))
    else $error("compare output did not toggle");

  c_pwm_wrap: cover property (is_pwm && wrap);
  c_capture: cover property (cap_evt ##1 irq_out);
  c_count_write: cover property (wr && (paddr_in == OFS_CNT_LO));
  c_ext_tick: cover property ((clk_sel == CS_EXT_FALL) && tick);

endmodule // sbta_top

// *** testbench/sbta_cpu_model.sv ***
// cpu-side bus master model: byte accesses over apb and ordered 16-bit pairs
`timescale 1ns/100ps
module sbta_cpu_model import sbta_pkg::*; (
  input wire logic clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  // ------------------------------------------------------------
  // bus idle at time zero
  // ------------------------------------------------------------
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
  end

  // one byte access; request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= {24'h000000, d};
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~pwdata_out; // stale data never looks valid
  endtask

  // high byte goes first so the low byte commits the pair
  task automatic wr16(input logic [7:0] lo_a, input logic [15:0] v);
    logic [31:0] r;
    logic e;
    xfer(1'b1, lo_a + 8'h04, v[15:8], r, e);
    xfer(1'b1, lo_a, v[7:0], r, e);
  endtask

  // low byte first freezes the high byte in the shared holding byte
  task automatic rd16(input logic [7:0] lo_a, output logic [15:0] v);
    logic [31:0] r;
    logic e;
    xfer(1'b0, lo_a, 8'h00, r, e);
    v[7:0] = r[7:0];
    xfer(1'b0, lo_a + 8'h04, 8'h00, r, e);
    v[15:8] = r[7:0];
  endtask
endmodule // sbta_cpu_model

// *** testbench/test_sixteen_bit_timer_access.sv ***
// self-checking bench of the sixteen-bit timer through its byte-wide register bus
`timescale 1ns/100ps
module test_sixteen_bit_timer_access import sbta_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ext_pin, cap_pin, out_a, out_b, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int fails = 0;
  int n_checks = 0;
  logic [15:0] v;
  logic [15:0] tops [7] = '{CNT_MAX, TOP_8, TOP_9, TOP_10, 16'h0040, 16'h0040, 16'h0040};
  int ahi, tog;
  logic [31:0] r0;
  logic e0;
  logic prev;

  always #20 core_clk = ~core_clk;

  sbta_top #(.FILT_LEN(4)) sbta_top_i (.core_clk_in(core_clk), .rst_b_in(rst_b),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .external_count_pin_in(ext_pin), .capture_input_pin_in(cap_pin),
    .compare_output_pin_a_out(out_a), .compare_output_pin_b_out(out_b), .irq_out(irq));

  sbta_cpu_model sbta_cpu_model_i (.clk_in(core_clk), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));

  // ------------------------------------------------------------
  // compare, access and verdict helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    sbta_cpu_model_i.xfer(1'b1, a, d, r, e);
  endtask

  // masked read compare; a full mask checks unused upper bits read zero
  task automatic rm(input string n, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    sbta_cpu_model_i.xfer(1'b0, a, 8'h00, r, e);
    chk(n, r & m, exp);
  endtask

  task automatic run(input logic [7:0] cs, input int n);
    wr(OFS_CTRL_B, cs);
    repeat (n) @(posedge core_clk);
    wr(OFS_CTRL_B, {5'h00, CS_NONE});
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk) ext_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask

  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchdog: the sequence needs well under this many cycles
  // ------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    rm("ctrl_b rst", OFS_CTRL_B, 32'hffffffff, 32'h0);
    rm("flags rst", OFS_IRQ_FLAG, 32'hffffffff, 32'h0);
    wr(OFS_CTRL_A, 8'h03);
    rm("ctrl_a", OFS_CTRL_A, 32'h7, 32'h3);
    wr(OFS_CTRL_A, 8'h00);
    // error flag stands only in the access cycle, so take it from the transfer itself
    sbta_cpu_model_i.xfer(1'b0, 8'h34, 8'h00, r0, e0);
    chk("unmapped", r0, 32'h0);
    chk("slverr", e0, 1'b1);
    // stopped counter keeps a pair write; power gate blocks ticks too
    sbta_cpu_model_i.wr16(OFS_CNT_LO, 16'h1234);
    repeat (20) @(posedge core_clk);
    sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
    chk("cnt still", v, 16'h1234);
    wr(OFS_CTRL_C, 8'h01);
    run({5'h00, CS_DIV1}, 20);
    sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
    chk("gated", v, 16'h1234);
    wr(OFS_CTRL_C, 8'h00);
    run({5'h00, CS_DIV1}, 10);
    sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
    chk("cnt moves", v != 16'h1234, 1'b1);
    // one holding byte shared by every pair register
    wr(OFS_CMPB_HI, 8'hab);
    rm("temp shared", OFS_CNT_HI, 32'hffffffff, 32'hab);
    wr(OFS_CMPA_LO, 8'h34);
    wr(OFS_CAP_HI, 8'h5a);
    rm("cmpa lo", OFS_CMPA_LO, 32'hff, 32'h34);
    rm("cmpa hi", OFS_CMPA_HI, 32'hff, 32'hab);
    rm("temp kept", OFS_CAP_HI, 32'hff, 32'h5a);
    rm("cnt lo", OFS_CNT_LO, 32'hff, {24'h0, v[7:0]});
    rm("cnt hi", OFS_CNT_HI, 32'hff, {24'h0, v[15:8]});
    // each mode except MODE_PWM_A wraps at its own top and flags the overflow
    sbta_cpu_model_i.wr16(OFS_CMPA_LO, 16'h0040);
    sbta_cpu_model_i.wr16(OFS_CAP_LO, 16'h0040);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_IRQ_FLAG, 8'h0f);
      wr(OFS_CTRL_A, i[7:0]);
      sbta_cpu_model_i.wr16(OFS_CNT_LO, tops[i] - 16'h0003);
      run({5'h00, CS_DIV1}, 12);
      rm("ovf", OFS_IRQ_FLAG, 32'h1, 32'h1);
      sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
      chk("wrapped", v < 16'h0020, 1'b1);
    end
    // compare flags and masked interrupt
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_IRQ_FLAG, 8'h0f);
    sbta_cpu_model_i.wr16(OFS_CMPB_LO, 16'h0038);
    sbta_cpu_model_i.wr16(OFS_CNT_LO, 16'h0030);
    run({5'h00, CS_DIV1}, 30);
    rm("cmp flags", OFS_IRQ_FLAG, 32'h6, 32'h6);
    chk("irq masked", irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h02);
    repeat (2) @(posedge core_clk);
    chk("irq on", irq, 1'b1);
    wr(OFS_IRQ_FLAG, 8'h02);
    repeat (2) @(posedge core_clk);
    chk("irq off", irq, 1'b0);
    rm("w1c", OFS_IRQ_FLAG, 32'hf, 32'h4);
    // filtered rising capture ignores a short glitch, then falling unfiltered
    wr(OFS_IRQ_FLAG, 8'h0f);
    wr(OFS_CTRL_B, 8'h19);
    @(posedge core_clk) cap_pin <= 1'b1;
    repeat (2) @(posedge core_clk);
    cap_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    rm("glitch", OFS_IRQ_FLAG, 32'h8, 32'h0);
    cap_pin <= 1'b1;
    run(8'h19, 12);
    rm("cap rise", OFS_IRQ_FLAG, 32'h8, 32'h8);
    sbta_cpu_model_i.rd16(OFS_CAP_LO, v);
    chk("cap value", v != 16'h0040, 1'b1);
    wr(OFS_IRQ_FLAG, 8'h08);
    wr(OFS_CTRL_B, 8'h01);
    cap_pin <= 1'b0;
    run(8'h01, 10);
    rm("cap fall", OFS_IRQ_FLAG, 32'h8, 32'h8);
    // external count pin, both edges
    sbta_cpu_model_i.wr16(OFS_CNT_LO, 16'h0000);
    wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
    pulses(5);
    sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
    chk("ext rise", v, 16'h0005);
    wr(OFS_CTRL_B, {5'h00, CS_EXT_FALL});
    pulses(3);
    wr(OFS_CTRL_B, {5'h00, CS_NONE});
    sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
    chk("ext fall", v, 16'h0008);
    // divide-by-eight tap: about 83 enabled cycles give ten ticks
    sbta_cpu_model_i.wr16(OFS_CNT_LO, 16'h0000);
    run({5'h00, CS_DIV8}, 80);
    sbta_cpu_model_i.rd16(OFS_CNT_LO, v);
    chk("div8", (v >= 16'h0009) && (v <= 16'h000b), 1'b1);
    // compare a as pulse-width top: pin a silent, pin b still modulates
    wr(OFS_CTRL_A, 8'h07);
    sbta_cpu_model_i.wr16(OFS_CMPA_LO, 16'h0020);
    sbta_cpu_model_i.wr16(OFS_CMPB_LO, 16'h0010);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    ahi = 0;
    tog = 0;
    prev = out_b;
    repeat (200) begin
      @(posedge core_clk);
      if (out_a !== 1'b0) ahi++;
      if (out_b !== prev) tog++;
      prev = out_b;
    end
    chk("pin a", ahi, 0);
    chk("pin b", tog >= 4, 1'b1);
    give_verdict();
  end
endmodule // test_sixteen_bit_timer_access
